// ---- src/elma_pkg.sv ----
package elma_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RX_CFG = 8'h28;
  localparam logic [7:0] IDX_MAINT2 = 8'h31;
  localparam logic [7:0] IDX_TERM = 8'h32;
  localparam logic [7:0] IDX_IEN0 = 8'h33;
  localparam logic [7:0] IDX_IEN1 = 8'h34;
  localparam logic [7:0] IDX_EDGE = 8'h35;
  localparam logic [7:0] IDX_LSTAT0 = 8'h36;
  localparam logic [7:0] IDX_LSTAT1 = 8'h37;
  localparam logic [7:0] IDX_ISTAT0 = 8'h3a;
  localparam logic [7:0] IDX_ISTAT1 = 8'h3b;
  localparam logic [7:0] IDX_CNTH = 8'h3c;
  localparam logic [7:0] IDX_CNTL = 8'h3d;
  localparam logic [7:0] IDX_NONE = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RX_CODE_BIT = 0;
  localparam int INJ_BIT = 6;
  localparam int CRIT_BIT = 4;
  localparam int CNTEN_LSB = 2;
  localparam int MODE_BIT = 1;
  localparam int TRIG_BIT = 0;
  localparam int TTERM_LSB = 3;
  localparam int RTERM_LSB = 0;
  localparam int DF_BIT = 2;
  localparam int LOS_BIT = 0;
  localparam int GAIN_LSB = 0;

  // Flag order: 0 loss, 1 driver fault, 2 count overflow, 3 code violation,
  // 4 zero run, 5 rx jitter fifo, 6 tx jitter fifo, 7 pulse sum
  localparam int NUM_FLAGS = 8;
  localparam logic [7:0] FLAG_IN_STAT1 = 8'hfc;
  localparam logic [7:0] FLAG_EDGE = 8'h03;
  localparam int FLAG_BIT [NUM_FLAGS] = '{0, 2, 0, 1, 2, 4, 5, 6};

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TTERM_RST = 3'h0;
  localparam logic [2:0] RTERM_RST = 3'h7;
  localparam logic [1:0] COUNT_EN_ON = 2'h1;
  localparam logic [6:0] ZR_AMI_ANSI = 7'h0f;
  localparam logic [6:0] ZR_AMI_FCC = 7'h50;
  localparam logic [6:0] ZR_HDB3 = 7'h03;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned REPORT_PERIOD_S = 1;
  localparam int unsigned REPORT_CYCLES = CLK_HZ * REPORT_PERIOD_S;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ = 3'b100
  } elma_bus_t;

endpackage : elma_pkg

// ---- src/elma_flag.sv ----
`timescale 1ns/100ps
module elma_flag #(
  parameter bit USE_EDGE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source and control
  input wire logic src,
  input wire logic edge_sel,
  input wire logic clr,
  // Sticky flag
  output logic flag
);

  logic prev;
  logic set;

  always_comb begin
    if (USE_EDGE) begin
      set = edge_sel ? (src ^ prev) : (src & ~prev);
    end else begin
      set = src;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= src;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
      (clr && !set) |=> !flag) else $error("flag not cleared by write one");
  a_rise_only: assert property (@(posedge clk) disable iff (rst)
      (USE_EDGE && !edge_sel && prev && !src && !flag) |=> !flag)
      else $error("falling edge set flag in rising mode");
  a_any_edge: assert property (@(posedge clk) disable iff (rst)
      (USE_EDGE && edge_sel && (prev != src)) |=> flag)
      else $error("edge missed in any-edge mode");

endmodule : elma_flag

// ---- src/elma_zero_run.sv ----
`timescale 1ns/100ps
module elma_zero_run (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Received stream
  input wire logic rx_data,
  input wire logic rx_data_valid,
  // Mode
  input wire logic hdb3_sel,
  input wire logic criteria_sel,
  // Event
  output logic zero_run_evt
);

  logic [6:0] run;
  logic [6:0] thr;

  always_comb begin
    if (hdb3_sel) begin
      thr = elma_pkg::ZR_HDB3;
    end else if (criteria_sel) begin
      thr = elma_pkg::ZR_AMI_FCC;
    end else begin
      thr = elma_pkg::ZR_AMI_ANSI;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 7'h00;
    end else if (rx_data_valid) begin
      if (rx_data) begin
        run <= 7'h00;
      end else if (run != 7'h7f) begin
        run <= run + 7'h01;
      end
    end
  end

  // Fires once per run, on the zero that first exceeds the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_run_evt <= 1'b0;
    end else begin
      zero_run_evt <= rx_data_valid && !rx_data && (run == thr);
    end
  end

  a_zero_limit: assert property (@(posedge clk) disable iff (rst)
      zero_run_evt |-> ($past(run) == ($past(hdb3_sel) ? 7'h03 :
      ($past(criteria_sel) ? 7'h50 : 7'h0f))))
      else $error("zero run event at wrong length");

endmodule : elma_zero_run

// ---- src/elma_regs.sv ----
`timescale 1ns/100ps
module elma_regs #(
  parameter int unsigned REPORT_CYCLES = elma_pkg::REPORT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Received stream from the line decoder
  input wire logic rx_data,
  input wire logic rx_data_valid,
  // Analog status pins
  input wire logic driver_fault_pin,
  input wire logic signal_loss_pin,
  input wire logic [4:0] receiver_gain_pin,
  // Event pulses from the data path
  input wire logic pulse_sum_evt,
  input wire logic tx_jitter_fifo_evt,
  input wire logic rx_jitter_fifo_evt,
  input wire logic code_violation_evt,
  // Transmit and line controls, and interrupt request
  output logic violation_insert,
  output logic [4:0] tx_term_match,
  output logic [4:0] rx_term_match,
  output logic irq
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic rx_line_code_sel;
  logic violation_inject;
  logic zero_run_criteria_sel;
  logic [1:0] zero_run_count_enable;
  logic counter_report_mode;
  logic counter_transfer_trigger;
  logic [2:0] tx_term;
  logic [2:0] rx_term;
  logic driver_fault_edge_sel;
  logic signal_loss_edge_sel;
  logic [7:0] irq_en;

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  elma_pkg::elma_bus_t state;
  logic [7:0] addr_q;
  logic accept;
  logic wr_stb;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // Status and counting
  // ----------------------------------------------------------------
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic driver_fault_live;
  logic signal_loss_live;
  logic [4:0] receiver_gain_level;
  logic [7:0] flag_src;
  logic [7:0] flag_edge_sel;
  logic [7:0] flag_clr;
  logic [7:0] flags;
  logic zero_run_evt;
  logic [15:0] count;
  logic [15:0] snapshot;
  logic [31:0] sec_cnt;
  logic sec_tick;
  logic trig_prev;
  logic inject_prev;
  logic manual_xfer;
  logic do_xfer;
  logic count_inc;
  logic count_ovf;

  function automatic logic [4:0] term_decode(input logic [2:0] sel);
    logic [4:0] m;
    m = 5'h00;
    if (sel[2]) begin
      m[4] = 1'b1;
    end else begin
      m[sel[1:0]] = 1'b1;
    end
    return m;
  endfunction : term_decode

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero-wait writes, one wait state on reads
  // ----------------------------------------------------------------
  assign accept = hsel && hready && htrans[1];
  assign wr_stb = (state == elma_pkg::BUS_WRITE);
  assign wbyte = hwdata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= elma_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
    end else begin
      case (state)
        elma_pkg::BUS_READ: begin
          state <= elma_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
        elma_pkg::BUS_IDLE, elma_pkg::BUS_WRITE: begin
          if (accept) begin
            addr_q <= (haddr[31:10] == 22'h000000) ? haddr[9:2] : elma_pkg::IDX_NONE;
            state <= hwrite ? elma_pkg::BUS_WRITE : elma_pkg::BUS_READ;
            hreadyout <= hwrite;
          end else begin
            state <= elma_pkg::BUS_IDLE;
          end
        end
        default: begin
          state <= elma_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (state == elma_pkg::BUS_READ) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (addr_q)
      elma_pkg::IDX_RX_CFG: rd_byte[elma_pkg::RX_CODE_BIT] = rx_line_code_sel;
      elma_pkg::IDX_MAINT2: begin
        rd_byte[elma_pkg::INJ_BIT] = violation_inject;
        rd_byte[elma_pkg::CRIT_BIT] = zero_run_criteria_sel;
        rd_byte[elma_pkg::CNTEN_LSB +: 2] = zero_run_count_enable;
        rd_byte[elma_pkg::MODE_BIT] = counter_report_mode;
        rd_byte[elma_pkg::TRIG_BIT] = counter_transfer_trigger;
      end
      elma_pkg::IDX_TERM: begin
        rd_byte[elma_pkg::TTERM_LSB +: 3] = tx_term;
        rd_byte[elma_pkg::RTERM_LSB +: 3] = rx_term;
      end
      elma_pkg::IDX_EDGE: begin
        rd_byte[elma_pkg::DF_BIT] = driver_fault_edge_sel;
        rd_byte[elma_pkg::LOS_BIT] = signal_loss_edge_sel;
      end
      elma_pkg::IDX_LSTAT0: begin
        rd_byte[elma_pkg::DF_BIT] = driver_fault_live;
        rd_byte[elma_pkg::LOS_BIT] = signal_loss_live;
      end
      elma_pkg::IDX_LSTAT1: rd_byte[elma_pkg::GAIN_LSB +: 5] = receiver_gain_level;
      elma_pkg::IDX_CNTH: rd_byte = snapshot[15:8];
      elma_pkg::IDX_CNTL: rd_byte = snapshot[7:0];
      elma_pkg::IDX_IEN0, elma_pkg::IDX_IEN1, elma_pkg::IDX_ISTAT0, elma_pkg::IDX_ISTAT1: begin
        for (int i = 0; i < elma_pkg::NUM_FLAGS; i++) begin
          if (addr_q == (elma_pkg::FLAG_IN_STAT1[i] ? elma_pkg::IDX_IEN1 : elma_pkg::IDX_IEN0)) begin
            rd_byte[elma_pkg::FLAG_BIT[i]] = irq_en[i];
          end
          if (addr_q == (elma_pkg::FLAG_IN_STAT1[i] ? elma_pkg::IDX_ISTAT1 : elma_pkg::IDX_ISTAT0)) begin
            rd_byte[elma_pkg::FLAG_BIT[i]] = flags[i];
          end
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_line_code_sel <= 1'b0;
      violation_inject <= 1'b0;
      zero_run_criteria_sel <= 1'b0;
      zero_run_count_enable <= 2'h0;
      counter_report_mode <= 1'b0;
      counter_transfer_trigger <= 1'b0;
      tx_term <= elma_pkg::TTERM_RST;
      rx_term <= elma_pkg::RTERM_RST;
      driver_fault_edge_sel <= 1'b0;
      signal_loss_edge_sel <= 1'b0;
    end else if (wr_stb) begin
      case (addr_q)
        elma_pkg::IDX_RX_CFG: rx_line_code_sel <= wbyte[elma_pkg::RX_CODE_BIT];
        elma_pkg::IDX_MAINT2: begin
          violation_inject <= wbyte[elma_pkg::INJ_BIT];
          zero_run_criteria_sel <= wbyte[elma_pkg::CRIT_BIT];
          zero_run_count_enable <= wbyte[elma_pkg::CNTEN_LSB +: 2];
          counter_report_mode <= wbyte[elma_pkg::MODE_BIT];
          counter_transfer_trigger <= wbyte[elma_pkg::TRIG_BIT];
        end
        elma_pkg::IDX_TERM: begin
          tx_term <= wbyte[elma_pkg::TTERM_LSB +: 3];
          rx_term <= wbyte[elma_pkg::RTERM_LSB +: 3];
        end
        elma_pkg::IDX_EDGE: begin
          driver_fault_edge_sel <= wbyte[elma_pkg::DF_BIT];
          signal_loss_edge_sel <= wbyte[elma_pkg::LOS_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {receiver_gain_pin, driver_fault_pin, signal_loss_pin};
      sync_b <= sync_a;
    end
  end

  assign signal_loss_live = sync_b[0];
  assign driver_fault_live = sync_b[1];
  assign receiver_gain_level = sync_b[6:2];

  // ----------------------------------------------------------------
  // Sticky flags and enables
  // ----------------------------------------------------------------
  assign flag_src = {pulse_sum_evt, tx_jitter_fifo_evt, rx_jitter_fifo_evt, zero_run_evt,
                     code_violation_evt, count_ovf, driver_fault_live, signal_loss_live};
  assign flag_edge_sel = {6'h00, driver_fault_edge_sel, signal_loss_edge_sel};

  generate
    for (genvar g = 0; g < elma_pkg::NUM_FLAGS; g++) begin : g_flag
      localparam logic [7:0] EN_IDX = elma_pkg::FLAG_IN_STAT1[g] ? elma_pkg::IDX_IEN1 :
                                      elma_pkg::IDX_IEN0;
      localparam logic [7:0] ST_IDX = elma_pkg::FLAG_IN_STAT1[g] ? elma_pkg::IDX_ISTAT1 :
                                      elma_pkg::IDX_ISTAT0;

      assign flag_clr[g] = wr_stb && (addr_q == ST_IDX) && wbyte[elma_pkg::FLAG_BIT[g]];

      always_ff @(posedge clk) begin
        if (rst) begin
          irq_en[g] <= 1'b0;
        end else if (wr_stb && (addr_q == EN_IDX)) begin
          irq_en[g] <= wbyte[elma_pkg::FLAG_BIT[g]];
        end
      end

      elma_flag #(
        .USE_EDGE(elma_pkg::FLAG_EDGE[g])
      ) u_flag (
        .clk(clk),
        .rst(rst),
        .src(flag_src[g]),
        .edge_sel(flag_edge_sel[g]),
        .clr(flag_clr[g]),
        .flag(flags[g])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Violation insertion
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      inject_prev <= 1'b0;
      violation_insert <= 1'b0;
    end else begin
      inject_prev <= violation_inject;
      violation_insert <= violation_inject && !inject_prev;
    end
  end

  // ----------------------------------------------------------------
  // Excessive zero detection and counting
  // ----------------------------------------------------------------
  elma_zero_run u_zero_run (
    .clk(clk),
    .rst(rst),
    .rx_data(rx_data),
    .rx_data_valid(rx_data_valid),
    .hdb3_sel(!rx_line_code_sel),
    .criteria_sel(zero_run_criteria_sel),
    .zero_run_evt(zero_run_evt)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      sec_cnt <= 32'h00000000;
      sec_tick <= 1'b0;
    end else if (sec_cnt == 32'(REPORT_CYCLES - 1)) begin
      sec_cnt <= 32'h00000000;
      sec_tick <= 1'b1;
    end else begin
      sec_cnt <= sec_cnt + 32'h00000001;
      sec_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= counter_transfer_trigger;
    end
  end

  assign manual_xfer = !counter_report_mode && counter_transfer_trigger && !trig_prev;
  assign do_xfer = counter_report_mode ? sec_tick : manual_xfer;
  assign count_inc = zero_run_evt && (zero_run_count_enable == elma_pkg::COUNT_EN_ON);
  assign count_ovf = count_inc && !do_xfer && (count == 16'hffff);

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
      snapshot <= 16'h0000;
    end else if (do_xfer) begin
      snapshot <= count;
      count <= {15'h0000, count_inc};
    end else if (count_inc) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_term_match <= 5'h00;
      rx_term_match <= 5'h00;
    end else begin
      tx_term_match <= term_decode(tx_term);
      rx_term_match <= term_decode(rx_term);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_inject_once: assert property (violation_insert |->
      ($past(violation_inject) && !$past(violation_inject, 2)) ##1 !violation_insert)
      else $error("violation insert without fresh rising edge");
  a_count_gate: assert property (($changed(count) && !$past(do_xfer)) |->
      ($past(zero_run_count_enable) == 2'h1 && $past(zero_run_evt)))
      else $error("counter moved without enabled event");
  a_manual_copy: assert property ((!counter_report_mode && counter_transfer_trigger &&
      !trig_prev) |=> (snapshot == $past(count)) && (count <= 16'h0001))
      else $error("manual transfer did not copy counter");
  a_auto_copy: assert property ((counter_report_mode && sec_tick) |=> snapshot == $past(count))
      else $error("auto transfer did not copy counter");
  a_trig_ignored: assert property ((counter_report_mode && !sec_tick) |=> $stable(snapshot))
      else $error("snapshot changed in auto mode off tick");
  a_irq_raise: assert property (|(flags & irq_en) |=> irq)
      else $error("enabled flag did not raise interrupt");
  a_irq_silent: assert property (((flags & irq_en) == 8'h00) [*2] |-> !irq)
      else $error("interrupt without enabled flag");
  a_count_wrap: assert property ((count_inc && !do_xfer && count == 16'hffff) |=>
      (flags[2] && count == 16'h0000))
      else $error("overflow flag not set on wrap");
  a_term_decode: assert property ((tx_term == 3'h1) ##1 (tx_term == 3'h1) |->
      tx_term_match == 5'h02)
      else $error("transmit 120 ohm decode wrong");
  a_rx_bypass: assert property (rx_term[2] ##1 rx_term[2] |-> rx_term_match == 5'h10)
      else $error("receive bypass decode wrong");

endmodule : elma_regs

// ---- test/elma_line_src.sv ----
`timescale 1ns/100ps
module elma_line_src (
  // Clock
  input wire logic clk,
  // Decoded receive stream
  output logic rx_data,
  output logic rx_data_valid
);
  initial begin
    rx_data = 1'b0;
    rx_data_valid = 1'b0;
  end

  // ----------------------------------------
  // Run of n zeros closed by a one
  // ----------------------------------------
  // Gap cycles between strobes carry a toggling, meaningless bit
  task automatic send(input int n, input int gap);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      rx_data <= (i == n);
      rx_data_valid <= 1'b1;
      repeat (gap) begin
        @(posedge clk);
        rx_data_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
    @(posedge clk);
    rx_data <= 1'b0;
    rx_data_valid <= 1'b0;
  endtask : send
endmodule : elma_line_src

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic clk, rst, hwrite, hreadyout, hresp, rdy, irq, violation_insert;
  logic [31:0] haddr, hwdata, hrdata, rdat, rv;
  logic [1:0] htrans;
  logic rx_data, rx_data_valid, driver_fault_pin, signal_loss_pin;
  logic [4:0] receiver_gain_pin, tx_term_match, rx_term_match;
  logic [3:0] ev;
  logic [2:0] k;
  int mismatches, total_checks, vins, cyc;

  elma_regs #(.REPORT_CYCLES(400)) dut (
    .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
    .driver_fault_pin(driver_fault_pin), .signal_loss_pin(signal_loss_pin),
    .receiver_gain_pin(receiver_gain_pin), .pulse_sum_evt(ev[3]),
    .tx_jitter_fifo_evt(ev[2]), .rx_jitter_fifo_evt(ev[1]), .code_violation_evt(ev[0]),
    .violation_insert(violation_insert), .tx_term_match(tx_term_match),
    .rx_term_match(rx_term_match), .irq(irq)
  );
  elma_line_src line (.clk(clk), .rx_data(rx_data), .rx_data_valid(rx_data_valid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Values standing just before each rising edge
  always @(negedge clk) begin
    rdy = hreadyout;
    rdat = hrdata;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (violation_insert === 1'b1) vins <= vins + 1;
    if (cyc > 20000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    rv = rdat;
  endtask : bus

  task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, rv, exp);
  endtask : rchk

  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst <= 1'b1;
    htrans <= 2'h0;
    haddr <= 32'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    ev <= 4'h0;
    driver_fault_pin <= 1'b0;
    signal_loss_pin <= 1'b0;
    receiver_gain_pin <= 5'h15;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("term", elma_pkg::IDX_TERM, 32'h07);
    rchk("maint2", elma_pkg::IDX_MAINT2, 32'h00);
    chk("hresp", {31'h0, hresp}, 32'h0);
    rchk("gain", elma_pkg::IDX_LSTAT1, 32'h15);
    bus(1'b1, elma_pkg::IDX_LSTAT1, 8'h00);
    rchk("gain_ro", elma_pkg::IDX_LSTAT1, 32'h15);
    rchk("unmapped", elma_pkg::IDX_NONE, 32'h00);
    for (int c = 0; c < 5; c++) begin
      k = c[2:0];
      bus(1'b1, elma_pkg::IDX_TERM, {2'h0, k, k});
      repeat (2) @(posedge clk);
      chk("tx_term", {27'h0, tx_term_match}, k[2] ? 32'h10 : 32'h1 << k);
      chk("rx_term", {27'h0, rx_term_match}, k[2] ? 32'h10 : 32'h1 << k);
    end
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h40);
    repeat (4) @(posedge clk);
    chk("inject", vins, 32'h1);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h40);
    repeat (4) @(posedge clk);
    chk("inject_held", vins, 32'h1);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h00);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h40);
    repeat (4) @(posedge clk);
    chk("inject_again", vins, 32'h2);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h04);
    line.send(3, 0);
    line.send(4, 1);
    bus(1'b1, elma_pkg::IDX_RX_CFG, 8'h01);
    line.send(15, 0);
    line.send(16, 0);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h14);
    line.send(80, 0);
    line.send(81, 2);
    bus(1'b1, elma_pkg::IDX_RX_CFG, 8'h00);
    line.send(3, 0);
    line.send(4, 0);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h15);
    repeat (3) @(posedge clk);
    rchk("cnt_h", elma_pkg::IDX_CNTH, 32'h00);
    rchk("cnt_l", elma_pkg::IDX_CNTL, 32'h04);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h08);
    line.send(4, 0);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h09);
    repeat (3) @(posedge clk);
    rchk("cnt_off", elma_pkg::IDX_CNTL, 32'h00);
    rchk("zr_flag", elma_pkg::IDX_ISTAT1, 32'h04);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h06);
    line.send(4, 0);
    for (int i = 0; i < 300 && rv !== 32'h1; i++) bus(1'b0, elma_pkg::IDX_CNTL, 8'h00);
    chk("auto_cnt", rv, 32'h1);
    bus(1'b1, elma_pkg::IDX_MAINT2, 8'h07);
    rchk("trig_auto", elma_pkg::IDX_CNTL, 32'h01);
    bus(1'b1, elma_pkg::IDX_ISTAT1, 8'hff);
    signal_loss_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("lstat0", elma_pkg::IDX_LSTAT0, 32'h01);
    rchk("los_rise", elma_pkg::IDX_ISTAT0, 32'h01);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b1, elma_pkg::IDX_IEN0, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    bus(1'b1, elma_pkg::IDX_ISTAT0, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    signal_loss_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rchk("los_fall0", elma_pkg::IDX_ISTAT0, 32'h00);
    bus(1'b1, elma_pkg::IDX_EDGE, 8'h05);
    signal_loss_pin <= 1'b1;
    driver_fault_pin <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, elma_pkg::IDX_ISTAT0, 8'h05);
    signal_loss_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rchk("los_fall1", elma_pkg::IDX_ISTAT0, 32'h01);
    rchk("df_live", elma_pkg::IDX_LSTAT0, 32'h04);
    bus(1'b1, elma_pkg::IDX_ISTAT0, 8'h01);
    ev <= 4'hf;
    @(posedge clk);
    ev <= 4'h0;
    repeat (2) @(posedge clk);
    rchk("istat1", elma_pkg::IDX_ISTAT1, 32'h72);
    chk("irq_ev_off", {31'h0, irq}, 32'h0);
    bus(1'b1, elma_pkg::IDX_IEN1, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq_ev_on", {31'h0, irq}, 32'h1);
    bus(1'b1, elma_pkg::IDX_ISTAT1, 8'h72);
    repeat (2) @(posedge clk);
    chk("irq_ev_clr", {31'h0, irq}, 32'h0);
    close_out();
  end
endmodule : testbench
